/* File: verilog/rtc_pkg.sv */
// Purpose: Constants for the backup-domain calendar clock
// Assumes: APB byte addresses, 32-bit words
// Notes: Event bit order is alarm A, alarm B, wakeup, tamper, timestamp
package rtc_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [12:0] OFS_TIME = 13'h0000;
  localparam logic [12:0] OFS_DATE = 13'h0004;
  localparam logic [12:0] OFS_CTRL = 13'h0008;
  localparam logic [12:0] OFS_PRESC = 13'h000C;
  localparam logic [12:0] OFS_SUBSEC = 13'h0010;
  localparam logic [12:0] OFS_WAKE = 13'h0014;
  localparam logic [12:0] OFS_ALRA = 13'h0018;
  localparam logic [12:0] OFS_ALRB = 13'h001C;
  localparam logic [12:0] OFS_ALRA_SS = 13'h0020;
  localparam logic [12:0] OFS_ALRB_SS = 13'h0024;
  localparam logic [12:0] OFS_STATUS = 13'h0028;
  localparam logic [12:0] OFS_MASK = 13'h002C;
  localparam logic [12:0] OFS_SRAM_CTRL = 13'h0030;
  // Backup word index range and SRAM window
  localparam logic [10:0] BKP_FIRST = 11'h014;
  localparam int BKP_COUNT = 20;
  localparam int SRAM_WORDS = 1024;
  // ----------------------------------------
  // Control and alarm field positions, event count
  // ----------------------------------------
  localparam int CTRL_FMT12 = 0;
  localparam int CTRL_CLKSEL = 1;
  localparam int CTRL_CAL_EN = 3;
  localparam int CTRL_WAKE_EN = 4;
  localparam int CTRL_ALRA_EN = 5;
  localparam int CTRL_ALRB_EN = 6;
  localparam int CTRL_WSEL = 8;
  localparam int ALR_WDSEL = 30;
  localparam int ALR_SS_MSK = 31;
  localparam int NUM_EVENTS = 5;
  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic [19:0] PRESC_RESET = 20'h0_7FFF;
  localparam logic [6:0] HSE_DIV_LAST = 7'h7F;
  localparam int CAL_BIT = 5;
  localparam logic [31:0] TIME_RESET = 32'h0000_0000;
  localparam logic [31:0] DATE_RESET = 32'h0001_0101;
  typedef enum logic [3:0] {
    CLK_LSE = 4'b0001,
    CLK_LSI = 4'b0010,
    CLK_HSE = 4'b0100,
    CLK_OFF = 4'b1000
  } clk_src_t;
endpackage

/* File: verilog/rtc_backup_domain.sv */
// Purpose: Calendar clock, alarms, wakeup timer, backup registers and SRAM
// Assumes: Clock pins far slower than pclk; two resets on one clock
// Notes: backup_resetn clears the backup domain, presetn the rest
//
// The implementer's own choices: the placing of the registers and register access over APB.
module rtc_backup_domain (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [12:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Backup domain
  input wire logic backup_resetn,
  input wire logic lse_clk,
  input wire logic lsi_clk,
  input wire logic hse_clk,
  input wire logic tamper_pin,
  input wire logic timestamp_pin,
  input wire logic standby_wake_pin,
  input wire logic external_reset_pin_n,
  input wire logic independent_watchdog,
  input wire logic on_battery,
  // Outputs
  output logic irq,
  output logic cal_out,
  output logic [4:0] external_event_lines,
  output logic stop_wake,
  output logic standby_wake
);
  logic [8:0] sync1, sync2, sync3, pin_rise;
  logic [31:0] ctrl, mask, status, wake_reload;
  logic [31:0] alr [2];
  logic [31:0] alr_ss [2];
  logic [31:0] bkp [rtc_pkg::BKP_COUNT];
  logic [31:0] sram [rtc_pkg::SRAM_WORDS];
  logic [19:0] presc, pcnt;
  logic [7:0] sec, min, hour, wday, date, month, year;
  logic [7:0] next_sec, next_min, next_hour, next_wday, next_date, next_month, next_year;
  logic pm, next_pm, sram_en;
  logic [6:0] hse_cnt;
  logic [5:0] cal_cnt;
  logic [3:0] wdiv;
  logic [15:0] wcnt;
  logic rtc_tick, sec_tick, wake_tick;
  logic [1:0] alr_hit, alr_hit_q;
  logic [4:0] ev;
  logic [31:0] rd;
  logic rd_err, wr, bkp_hit;
  logic [10:0] widx;
  logic [4:0] bidx;
  rtc_pkg::clk_src_t src;

  assign widx = paddr[12:2];
  assign bidx = 5'(widx - rtc_pkg::BKP_FIRST);
  assign bkp_hit = widx >= rtc_pkg::BKP_FIRST && widx < rtc_pkg::BKP_FIRST + 11'(rtc_pkg::BKP_COUNT);
  assign wr = psel & penable & pready & pwrite;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] days_in(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: days_in = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: days_in = 8'h30;
      default: days_in = 8'h31;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {on_battery, independent_watchdog, ~external_reset_pin_n, standby_wake_pin,
                timestamp_pin, tamper_pin, hse_clk, lsi_clk, lse_clk};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign pin_rise = sync2 & ~sync3;

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  always_comb begin
    case (ctrl[rtc_pkg::CTRL_CLKSEL +: 2])
      2'd0: src = rtc_pkg::CLK_LSE;
      2'd1: src = rtc_pkg::CLK_LSI;
      2'd2: src = rtc_pkg::CLK_HSE;
      default: src = rtc_pkg::CLK_OFF;
    endcase
    case (src)
      rtc_pkg::CLK_LSE: rtc_tick = pin_rise[0];
      rtc_pkg::CLK_LSI: rtc_tick = pin_rise[1];
      rtc_pkg::CLK_HSE: rtc_tick = pin_rise[2] && hse_cnt == rtc_pkg::HSE_DIV_LAST;
      default: rtc_tick = 1'b0;
    endcase
  end
  assign sec_tick = rtc_tick && pcnt == 20'h0_0000;

  always_ff @(posedge pclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      hse_cnt <= '0;
      cal_cnt <= '0;
      pcnt <= rtc_pkg::PRESC_RESET;
    end else begin
      if (pin_rise[2]) hse_cnt <= hse_cnt + 7'h01;
      if (rtc_tick) cal_cnt <= cal_cnt + 6'h01;
      if (wr && paddr == rtc_pkg::OFS_PRESC) pcnt <= pwdata[19:0];
      else if (sec_tick) pcnt <= presc;
      else if (rtc_tick) pcnt <= pcnt - 20'h0_0001;
    end
  end

  // ----------------------------------------
  // Calendar
  // ----------------------------------------
  always_comb begin
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_pm = pm;
    next_wday = wday;
    next_date = date;
    next_month = month;
    next_year = year;
    if (sec_tick) begin
      next_sec = bcd_inc(sec);
      if (sec == 8'h59) begin
        next_sec = 8'h00;
        next_min = bcd_inc(min);
        if (min == 8'h59) begin
          next_min = 8'h00;
          next_hour = bcd_inc(hour);
          if (ctrl[rtc_pkg::CTRL_FMT12]) begin
            if (hour == 8'h11) next_pm = ~pm;
            if (hour == 8'h12) next_hour = 8'h01;
          end else if (hour == 8'h23) begin
            next_hour = 8'h00;
          end
          if (ctrl[rtc_pkg::CTRL_FMT12] ? (hour == 8'h11 && pm) : hour == 8'h23) begin
            next_wday = (wday == 8'h07) ? 8'h01 : wday + 8'h01;
            next_date = bcd_inc(date);
            if (date == days_in(month, year)) begin
              next_date = 8'h01;
              next_month = bcd_inc(month);
              if (month == 8'h12) begin
                next_month = 8'h01;
                next_year = (year == 8'h99) ? 8'h00 : bcd_inc(year);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      {pm, hour, min, sec} <= rtc_pkg::TIME_RESET[24:0];
      {year, wday, month, date} <= rtc_pkg::DATE_RESET;
    end else if (wr && paddr == rtc_pkg::OFS_TIME) begin
      {pm, hour, min, sec} <= pwdata[24:0];
    end else if (wr && paddr == rtc_pkg::OFS_DATE) begin
      {year, wday, month, date} <= pwdata;
    end else begin
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      pm <= next_pm;
      wday <= next_wday;
      date <= next_date;
      month <= next_month;
      year <= next_year;
    end
  end

  // ----------------------------------------
  // Backup-domain control and alarms
  // ----------------------------------------
  always_ff @(posedge pclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      ctrl <= '0;
      presc <= rtc_pkg::PRESC_RESET;
      wake_reload <= '0;
      alr <= '{default: '0};
      alr_ss <= '{default: '0};
    end else if (wr) begin
      case (paddr)
        rtc_pkg::OFS_CTRL: ctrl <= pwdata;
        rtc_pkg::OFS_PRESC: presc <= pwdata[19:0];
        rtc_pkg::OFS_WAKE: wake_reload <= {16'h0000, pwdata[15:0]};
        rtc_pkg::OFS_ALRA: alr[0] <= pwdata;
        rtc_pkg::OFS_ALRB: alr[1] <= pwdata;
        rtc_pkg::OFS_ALRA_SS: alr_ss[0] <= pwdata;
        rtc_pkg::OFS_ALRB_SS: alr_ss[1] <= pwdata;
        default: ;
      endcase
    end
  end

  for (genvar a = 0; a < 2; a++) begin : g_alarm
    logic [31:0] r;
    logic day_ok;
    assign r = alr[a];
    assign day_ok = r[rtc_pkg::ALR_WDSEL] ? r[27:24] == wday[3:0] : r[29:24] == date[5:0];
    // Masked fields always match
    assign alr_hit[a] = ctrl[rtc_pkg::CTRL_ALRA_EN + a]
      && (r[7] || r[6:0] == sec[6:0])
      && (r[15] || r[14:8] == min[6:0])
      && (r[23] || (r[21:16] == hour[5:0] && (!ctrl[rtc_pkg::CTRL_FMT12] || r[22] == pm)))
      && (r[31] || day_ok)
      && (alr_ss[a][rtc_pkg::ALR_SS_MSK] || alr_ss[a][19:0] == pcnt);
  end

  // ----------------------------------------
  // Wakeup timer
  // ----------------------------------------
  always_comb begin
    case (ctrl[rtc_pkg::CTRL_WSEL +: 3])
      3'd0: wake_tick = rtc_tick && wdiv[3:0] == 4'hF;
      3'd1: wake_tick = rtc_tick && wdiv[2:0] == 3'h7;
      3'd2: wake_tick = rtc_tick && wdiv[1:0] == 2'h3;
      3'd3: wake_tick = rtc_tick && wdiv[0];
      default: wake_tick = sec_tick;
    endcase
  end

  always_ff @(posedge pclk or negedge backup_resetn) begin
    if (!backup_resetn) begin
      wdiv <= '0;
      wcnt <= '0;
      alr_hit_q <= '0;
    end else begin
      alr_hit_q <= alr_hit;
      if (rtc_tick) wdiv <= wdiv + 4'h1;
      if (!ctrl[rtc_pkg::CTRL_WAKE_EN]) wcnt <= wake_reload[15:0];
      else if (wake_tick) wcnt <= (wcnt == 16'h0000) ? wake_reload[15:0] : wcnt - 16'h0001;
    end
  end

  assign ev = {pin_rise[4], pin_rise[3],
               ctrl[rtc_pkg::CTRL_WAKE_EN] && wake_tick && wcnt == 16'h0000,
               alr_hit & ~alr_hit_q};

  // ----------------------------------------
  // Backup registers and SRAM
  // ----------------------------------------
  for (genvar b = 0; b < rtc_pkg::BKP_COUNT; b++) begin : g_bkp
    always_ff @(posedge pclk or negedge backup_resetn) begin
      if (!backup_resetn) bkp[b] <= '0;
      else if (wr && bkp_hit && bidx == 5'(b)) bkp[b] <= pwdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && paddr[12] && sram_en) sram[paddr[11:2]] <= pwdata;
  end

  // ----------------------------------------
  // System registers, interrupt and wake
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
      status <= '0;
      sram_en <= 1'b0;
    end else begin
      if (wr && paddr == rtc_pkg::OFS_MASK) mask <= {27'h000_0000, pwdata[4:0]};
      if (wr && paddr == rtc_pkg::OFS_SRAM_CTRL) sram_en <= pwdata[0];
      // Set wins over a write-one clear
      status <= (status & ~((wr && paddr == rtc_pkg::OFS_STATUS) ? {27'h000_0000, pwdata[4:0]}
                                                                 : 32'h0000_0000))
                | {27'h000_0000, ev};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      cal_out <= 1'b0;
      external_event_lines <= '0;
      stop_wake <= 1'b0;
      standby_wake <= 1'b0;
    end else begin
      irq <= |(status[4:0] & mask[4:0]);
      cal_out <= ctrl[rtc_pkg::CTRL_CAL_EN] & cal_cnt[rtc_pkg::CAL_BIT];
      external_event_lines <= sync2[8] ? 5'h00 : ev;
      stop_wake <= ~sync2[8] & (|ev);
      standby_wake <= ~sync2[8] & ((|ev) | (|pin_rise[7:5]));
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  always_comb begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr[12]) begin
      if (sram_en) rd = sram[paddr[11:2]];
      else rd_err = 1'b1;
    end else if (bkp_hit) begin
      rd = bkp[bidx];
    end else begin
      case (paddr)
        rtc_pkg::OFS_TIME: rd = {7'h00, pm, hour, min, sec};
        rtc_pkg::OFS_DATE: rd = {year, wday, month, date};
        rtc_pkg::OFS_CTRL: rd = ctrl;
        rtc_pkg::OFS_PRESC: rd = {12'h000, presc};
        rtc_pkg::OFS_SUBSEC: rd = {12'h000, pcnt};
        rtc_pkg::OFS_WAKE: rd = {wcnt, wake_reload[15:0]};
        rtc_pkg::OFS_ALRA: rd = alr[0];
        rtc_pkg::OFS_ALRB: rd = alr[1];
        rtc_pkg::OFS_ALRA_SS: rd = alr_ss[0];
        rtc_pkg::OFS_ALRB_SS: rd = alr_ss[1];
        rtc_pkg::OFS_STATUS: rd = status;
        rtc_pkg::OFS_MASK: rd = mask;
        rtc_pkg::OFS_SRAM_CTRL: rd = {31'h0000_0000, sram_en};
        default: rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & rd_err;
      if (psel && !penable && !pwrite) prdata <= rd;
    end
  end
endmodule

/* File: tb/rtc_backup_domain_assertions.sv */
// Purpose: Port checks for the calendar block
// Assumes: presetn gates every check
// Notes: Bound to the design at the foot
module rtc_backup_domain_assertions (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and events
  input wire logic tamper_pin,
  input wire logic standby_wake_pin,
  input wire logic on_battery,
  input wire logic [4:0] external_event_lines,
  input wire logic stop_wake,
  input wire logic standby_wake
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_one_a: assert property (pready |=> !pready) else $error("pready too long");
  ready_setup_a: assert property (psel && !penable |=> pready) else $error("no pready");
  ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  battery_block_a: assert property (on_battery && $past(on_battery) && $past(on_battery, 2)
    && $past(on_battery, 3) |->
    !stop_wake && !standby_wake && external_event_lines == 5'h00) else $error("battery");
  event_stop_a: assert property (|external_event_lines |-> stop_wake) else $error("stop");
  stop_standby_a: assert property (stop_wake |-> standby_wake) else $error("standby");
  pin_wake_a: assert property ($rose(standby_wake_pin) && !on_battery |->
    ##[1:4] standby_wake) else $error("wake pin ignored");
  tamper_line_a: assert property ($rose(tamper_pin) && !on_battery |->
    ##[1:5] external_event_lines[3]) else $error("tamper line");
  alarm_pulse_a: assert property (external_event_lines[0] |=> !external_event_lines[0])
    else $error("alarm pulse long");
  cover property (pready && pslverr);
  cover property (standby_wake);
  cover property (external_event_lines[0]);
endmodule

bind rtc_backup_domain rtc_backup_domain_assertions chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .tamper_pin(tamper_pin),
  .standby_wake_pin(standby_wake_pin), .on_battery(on_battery),
  .external_event_lines(external_event_lines), .stop_wake(stop_wake),
  .standby_wake(standby_wake));

/* File: tb/rtc_backup_domain_tb_top.sv */
// Purpose: Self-checking bench for the calendar block
// Assumes: PRESC cut to 3, so one second is 32 pclk
// Notes: Slow clocks come from a pclk counter
module rtc_backup_domain_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re, backup_resetn;
  logic lse_clk, lsi_clk, hse_clk, tamper_pin, wake_pin, on_battery, irq, stop_wake;
  logic standby_wake, cal_out;
  logic sw_seen = 1'b0;
  logic st_seen = 1'b0;
  logic cal_seen = 1'b0;
  logic [4:0] ev;
  logic [12:0] paddr, sa;
  logic [31:0] pwdata, prdata, rq, d;
  logic [31:0] bk [20];
  logic [3:0] cnt = 4'h0;
  logic [31:0] dates [7] = '{32'h2301_0228, 32'h2402_0228, 32'h2403_0229, 32'h2104_0430,
    32'h2107_0131, 32'h9905_1231, 32'h1203_0500};
  int n_errors = 0;
  int n_checks = 0;
  int r, n;

  rtc_backup_domain dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .backup_resetn(backup_resetn), .lse_clk(lse_clk), .lsi_clk(lsi_clk),
    .hse_clk(hse_clk), .tamper_pin(tamper_pin), .timestamp_pin(1'b0),
    .standby_wake_pin(wake_pin), .external_reset_pin_n(1'b1), .independent_watchdog(1'b0),
    .on_battery(on_battery), .irq(irq), .cal_out(cal_out), .external_event_lines(ev),
    .stop_wake(stop_wake), .standby_wake(standby_wake));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cnt <= cnt + 4'h1;
    lse_clk <= cnt[2];
    lsi_clk <= cnt[3];
    hse_clk <= cnt[1];
  end
  // Sticky catchers for the one-cycle wake pulses and for the cal_out level
  always @(posedge pclk) begin
    if (standby_wake === 1'b1) sw_seen <= 1'b1;
    if (stop_wake === 1'b1) st_seen <= 1'b1;
    if (cal_out === 1'b1) cal_seen <= 1'b1;
  end
  // ----------------------------------------
  // Driver tasks
  // ----------------------------------------
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [12:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input logic [31:0] b);
    int t;
    t = 0;
    do begin acc(0, rtc_pkg::OFS_STATUS, 32'h0); t++; end while ((rq & b) === 0 && t < 200);
  endtask
  function automatic logic [7:0] inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  function automatic logic [31:0] next_date(input logic [31:0] v);
    logic [7:0] y, w, m, dt, last;
    {y, w, m, dt} = v;
    case (m)
      8'h02: last = (((y[4] ? y[3:0] + 2 : y[3:0]) % 4) == 0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last = 8'h30;
      default: last = 8'h31;
    endcase
    w = (w == 8'h07) ? 8'h01 : w + 8'h01;
    if (dt != last) dt = inc(dt);
    else begin
      dt = 8'h01;
      y = (m != 8'h12) ? y : (y == 8'h99) ? 8'h00 : inc(y);
      m = (m == 8'h12) ? 8'h01 : inc(m);
    end
    return {y, w, m, dt};
  endfunction
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, presetn, backup_resetn, tamper_pin, wake_pin} = 7'h00;
    on_battery = 1'b0;
    paddr = 13'h0000;
    pwdata = 32'h0000_0000;
    r = $urandom(32'hfd6ef651);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    backup_resetn <= 1'b1;
    @(posedge pclk);
    acc(0, rtc_pkg::OFS_TIME, 32'h0);
    chk("time_rst", rq, rtc_pkg::TIME_RESET);
    acc(0, rtc_pkg::OFS_DATE, 32'h0);
    chk("date_rst", rq, rtc_pkg::DATE_RESET);
    acc(0, rtc_pkg::OFS_PRESC, 32'h0);
    chk("presc_rst", rq, 32'(rtc_pkg::PRESC_RESET));
    acc(0, 13'h1000, 32'h0);
    chk("sram_off", 32'(re), 32'h1);
    acc(0, 13'h0040, 32'h0);
    chk("unmapped", 32'(re), 32'h1);
    acc(1, rtc_pkg::OFS_SRAM_CTRL, 32'h1);
    sa = 13'h1000 + 13'($urandom_range(1023)) * 13'h4;
    d = $urandom;
    acc(1, sa, d);
    acc(0, sa, 32'h0);
    chk("sram", rq, d);
    for (int i = 0; i < rtc_pkg::BKP_COUNT; i++) begin
      bk[i] = $urandom;
      acc(1, {rtc_pkg::BKP_FIRST, 2'b00} + 13'(i * 4), bk[i]);
    end
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < rtc_pkg::BKP_COUNT; i++) begin
      acc(0, {rtc_pkg::BKP_FIRST, 2'b00} + 13'(i * 4), 32'h0);
      chk("backup", rq, bk[i]);
    end
    acc(1, rtc_pkg::OFS_PRESC, 32'h3);
    r = $urandom_range(27, 1);
    dates[6][7:0] = 8'((r / 10) * 16 + r % 10);
    foreach (dates[k]) begin
      acc(1, rtc_pkg::OFS_DATE, dates[k]);
      acc(1, rtc_pkg::OFS_TIME, 32'h0023_5959);
      n = 0;
      do begin acc(0, rtc_pkg::OFS_DATE, 32'h0); n++; end while (rq === dates[k] && n < 50);
      chk("date", rq, next_date(dates[k]));
      acc(0, rtc_pkg::OFS_TIME, 32'h0);
      chk("time", rq, 32'h0);
    end
    acc(1, rtc_pkg::OFS_CTRL, 32'h0000_0001);
    acc(1, rtc_pkg::OFS_DATE, dates[0]);
    acc(1, rtc_pkg::OFS_TIME, 32'h0111_5959);
    n = 0;
    do begin acc(0, rtc_pkg::OFS_DATE, 32'h0); n++; end while (rq === dates[0] && n < 50);
    chk("date12", rq, next_date(dates[0]));
    acc(0, rtc_pkg::OFS_TIME, 32'h0);
    chk("time12", rq, 32'h0012_0000);
    acc(0, rtc_pkg::OFS_SUBSEC, 32'h0);
    chk("subsec", rq & 32'hFFFF_FFFC, 32'h0);
    acc(1, rtc_pkg::OFS_ALRA, 32'h8080_8005);
    acc(1, rtc_pkg::OFS_ALRA_SS, 32'h8000_0000);
    acc(1, rtc_pkg::OFS_MASK, 32'h1);
    acc(1, rtc_pkg::OFS_STATUS, 32'h1F);
    acc(1, rtc_pkg::OFS_TIME, 32'h0000_0003);
    acc(1, rtc_pkg::OFS_CTRL, 32'h0000_0020);
    poll(32'h1);
    chk("alarm", rq & 32'h1, 32'h1);
    chk("irq_on", 32'(irq), 32'h1);
    acc(1, rtc_pkg::OFS_STATUS, 32'h1);
    @(posedge pclk);
    chk("irq_off", 32'(irq), 32'h0);
    tamper_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("irq_msk", 32'(irq), 32'h0);
    acc(0, rtc_pkg::OFS_STATUS, 32'h0);
    chk("tamper", rq & 32'h8, 32'h8);
    chk("stop_wk", 32'(st_seen), 32'h1);
    tamper_pin <= 1'b0;
    acc(1, rtc_pkg::OFS_WAKE, 32'h1);
    acc(1, rtc_pkg::OFS_CTRL, 32'h0000_0418);
    acc(1, rtc_pkg::OFS_MASK, 32'h4);
    poll(32'h4);
    chk("wake", rq & 32'h4, 32'h4);
    chk("irq_wk", 32'(irq), 32'h1);
    acc(0, rtc_pkg::OFS_WAKE, 32'h0);
    chk("wake_rl", rq & 32'hFFFF, 32'h1);
    sw_seen <= 1'b0;
    wake_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("sb_wake", 32'(sw_seen), 32'h1);
    repeat (260) @(posedge pclk);
    chk("cal_out", 32'(cal_seen), 32'h1);
    on_battery <= 1'b1;
    wake_pin <= 1'b0;
    tamper_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("bat_ev", 32'(ev), 32'h0);
    on_battery <= 1'b0;
    tamper_pin <= 1'b0;
    stop_test;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    stop_test;
  end
endmodule
